// File: core/irq_rst_consts.svh
`ifndef IRQ_RST_CONSTS_SVH
`define IRQ_RST_CONSTS_SVH
// Register offsets
`define OFS_SOFT_RESET 5'h01
`define OFS_GLOBAL_CFG 5'h02
`define OFS_MASK_LOW 5'h14
`define OFS_MASK_HIGH 5'h15
`define OFS_EDGE_SEL 5'h16
`define OFS_LIVE_LOW 5'h17
`define OFS_LIVE_HIGH 5'h18
`define OFS_FLAG_LOW 5'h19
`define OFS_FLAG_HIGH 5'h1a
// Field positions in global_config
`define GCF_PIN_LSB 0
`define GCF_T1E1_BIT 2
// Reset values
`define RST_GLOBAL_CFG 8'h00
`define RST_MASK 8'hff
`define RST_EDGE_SEL 8'h00
`define RST_FLAG 8'h00
// Timing
`define CLK_PERIOD_NS 20
`define SOFT_RESET_NS 1000
`define SOFT_RESET_CYC ((`SOFT_RESET_NS) / (`CLK_PERIOD_NS))
`endif

// File: core/irq_rst_pkg.sv
package irq_rst_pkg;
  // Host register access, one word per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  // Interrupt pin driving style
  typedef enum logic [1:0] {
    PIN_OD_LOW = 2'b00,
    PIN_PP_LOW = 2'b01,
    PIN_PP_HIGH = 2'b10,
    PIN_OD_LOW2 = 2'b11
  } pin_style_t;
endpackage : irq_rst_pkg

// File: core/soft_reset_timer.sv
`include "irq_rst_consts.svh"
// Stretches a soft reset trigger into a reset pulse of fixed length
module soft_reset_timer #(
  parameter int CYCLES = `SOFT_RESET_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic trigger,
  output logic busy
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // Count down while busy
  always_comb begin
    cnt_nxt = cnt_r;
    if (trigger) begin
      cnt_nxt = 8'(CYCLES - 1);
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Busy comes from the counter alone so the trigger gate upstream forms no loop
  assign busy = (cnt_r != 8'h00);
endmodule : soft_reset_timer

// File: core/line_irq_reset.sv
`include "irq_rst_consts.svh"
// Function
// - Pin styles 00 and 11 give open-drain active-low interrupt output.
// - Style 01 drives the interrupt pin push-pull active low.
// - Style 10 drives the interrupt pin push-pull active high.
// - One pin shows active level whenever any enabled interrupt is pending.
// - Every event latches into its own bit of two flag registers.
// - Each source has its own enable bit in two mask registers.
// - Edge select bit chooses which live-status changes set the flag.
// - Reading either flag register returns the pin inactive.
// - Eight sources have live, flag, edge select and mask bits.
// - Eight sources have only flag and mask bits.
// - Any write to soft reset register resets chip within one microsecond.
// - After reset line driver outputs go high impedance.
// - After reset all flags clear and registers take defaults.
// - Mask zero lets a source interrupt, mask one blocks it.
// - Reading a flag register clears its latched bits.
module line_irq_reset (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hw_reset_n,
  input irq_rst_pkg::reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [7:0] live_low,
  input wire logic [7:0] live_high,
  input wire logic [7:0] event_high,
  output logic irq_o,
  output logic irq_oe,
  output logic line_drive_en,
  output logic chip_reset
);
  import irq_rst_pkg::*;

  logic soft_trig;
  logic soft_busy;
  logic any_reset;
  logic hw_reset_n_r;
  logic [7:0] gcf_r;
  logic [7:0] gcf_nxt;
  logic [7:0] mask_lo_r;
  logic [7:0] mask_lo_nxt;
  logic [7:0] mask_hi_r;
  logic [7:0] mask_hi_nxt;
  logic [7:0] edge_r;
  logic [7:0] edge_nxt;
  logic [7:0] flag_lo_r;
  logic [7:0] flag_lo_nxt;
  logic [7:0] flag_hi_r;
  logic [7:0] flag_hi_nxt;
  logic [7:0] live_prev_r;
  logic [7:0] live_prev_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;
  logic irq_o_nxt;
  logic irq_oe_nxt;
  logic pending;
  logic [7:0] live_edge;
  pin_style_t style;

  // Picks flag-setting changes per edge select bit
  function automatic logic [7:0] edge_hits(input logic [7:0] cur, input logic [7:0] prev,
                                           input logic [7:0] sel);
    edge_hits = (cur & ~prev) | (sel & (cur ^ prev));
  endfunction : edge_hits

  // Software reset stretcher
  assign soft_trig = req.wr && (req.addr == `OFS_SOFT_RESET) && !soft_busy;
  soft_reset_timer #(.CYCLES(`SOFT_RESET_CYC)) u_soft (
    .mclk(mclk),
    .rst(rst),
    .trigger(soft_trig),
    .busy(soft_busy)
  );

  // Hardware reset pin sampled, either source resets the chip
  always_ff @(posedge mclk) begin
    if (rst) begin
      hw_reset_n_r <= 1'b1; // Idle level of the pin, so no extra reset cycle
    end else begin
      hw_reset_n_r <= hw_reset_n;
    end
  end
  assign any_reset = rst || !hw_reset_n_r || soft_busy;

  // Register writes
  always_comb begin
    gcf_nxt = gcf_r;
    mask_lo_nxt = mask_lo_r;
    mask_hi_nxt = mask_hi_r;
    edge_nxt = edge_r;
    if (req.wr) begin
      unique case (req.addr)
        `OFS_GLOBAL_CFG: gcf_nxt = {5'h00, req.wdata[2:0]};
        `OFS_MASK_LOW: mask_lo_nxt = req.wdata;
        `OFS_MASK_HIGH: mask_hi_nxt = req.wdata;
        `OFS_EDGE_SEL: edge_nxt = req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      gcf_r <= `RST_GLOBAL_CFG;
      mask_lo_r <= `RST_MASK;
      mask_hi_r <= `RST_MASK;
      edge_r <= `RST_EDGE_SEL;
    end else begin
      gcf_r <= gcf_nxt;
      mask_lo_r <= mask_lo_nxt;
      mask_hi_r <= mask_hi_nxt;
      edge_r <= edge_nxt;
    end
  end

  // Flag latching with read clear; a new event wins over the clear
  assign live_edge = edge_hits(live_low, live_prev_r, edge_r);
  always_comb begin
    live_prev_nxt = live_low;
    flag_lo_nxt = flag_lo_r;
    flag_hi_nxt = flag_hi_r;
    if (req.rd && req.addr == `OFS_FLAG_LOW) begin
      flag_lo_nxt = 8'h00;
    end
    if (req.rd && req.addr == `OFS_FLAG_HIGH) begin
      flag_hi_nxt = 8'h00;
    end
    flag_lo_nxt = flag_lo_nxt | live_edge;
    flag_hi_nxt = flag_hi_nxt | event_high;
  end

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      flag_lo_r <= `RST_FLAG;
      flag_hi_r <= `RST_FLAG;
      live_prev_r <= 8'h00;
    end else begin
      flag_lo_r <= flag_lo_nxt;
      flag_hi_r <= flag_hi_nxt;
      live_prev_r <= live_prev_nxt;
    end
  end

  // Read data path
  always_comb begin
    rdata_nxt = 8'h00;
    rvalid_nxt = req.rd;
    if (req.rd) begin
      unique case (req.addr)
        `OFS_GLOBAL_CFG: rdata_nxt = gcf_r;
        `OFS_MASK_LOW: rdata_nxt = mask_lo_r;
        `OFS_MASK_HIGH: rdata_nxt = mask_hi_r;
        `OFS_EDGE_SEL: rdata_nxt = edge_r;
        `OFS_LIVE_LOW: rdata_nxt = live_low;
        `OFS_LIVE_HIGH: rdata_nxt = live_high;
        `OFS_FLAG_LOW: rdata_nxt = flag_lo_r;
        `OFS_FLAG_HIGH: rdata_nxt = flag_hi_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Interrupt pin: masked flags combined; a flag read forces inactive
  assign style = pin_style_t'(gcf_r[`GCF_PIN_LSB +: 2]);
  assign pending = (|(flag_lo_r & ~mask_lo_r) || |(flag_hi_r & ~mask_hi_r))
                   && !(req.rd && (req.addr == `OFS_FLAG_LOW || req.addr == `OFS_FLAG_HIGH));
  always_comb begin
    irq_o_nxt = 1'b1;
    irq_oe_nxt = 1'b0;
    unique case (style)
      PIN_PP_LOW: begin
        irq_o_nxt = !pending;
        irq_oe_nxt = 1'b1;
      end
      PIN_PP_HIGH: begin
        irq_o_nxt = pending;
        irq_oe_nxt = 1'b1;
      end
      default: begin
        irq_o_nxt = 1'b0;
        irq_oe_nxt = pending;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
      irq_o <= 1'b0;
      irq_oe <= 1'b0;
      line_drive_en <= 1'b0;
      chip_reset <= 1'b1;
    end else begin
      rdata <= rdata_nxt;
      rvalid <= rvalid_nxt;
      irq_o <= irq_o_nxt;
      irq_oe <= irq_oe_nxt;
      line_drive_en <= 1'b1;
      chip_reset <= 1'b0;
    end
  end

  // Checks
  mask_blocks_a: assert property (@(posedge mclk) disable iff (any_reset)
    (mask_lo_r == 8'hff && mask_hi_r == 8'hff && $stable(mask_lo_r) && $stable(mask_hi_r)
     && style == PIN_PP_HIGH && $stable(style)) |=> !irq_o)
    else $error("masked flags raised interrupt");
  rise_sets_a: assert property (@(posedge mclk) disable iff (any_reset)
    (live_low[0] && !live_prev_r[0]) |=> flag_lo_r[0])
    else $error("rising live bit did not set flag");
  fall_needs_sel_a: assert property (@(posedge mclk) disable iff (any_reset)
    (!live_low[1] && live_prev_r[1] && !edge_r[1] && !flag_lo_r[1]) |=> !flag_lo_r[1])
    else $error("falling edge set flag without select");
  read_clears_a: assert property (@(posedge mclk) disable iff (any_reset)
    (req.rd && req.addr == `OFS_FLAG_HIGH && event_high == 8'h00) |=> flag_hi_r == 8'h00)
    else $error("flag read did not clear");
  read_quiets_a: assert property (@(posedge mclk) disable iff (any_reset)
    (req.rd && req.addr == `OFS_FLAG_LOW && style == PIN_PP_HIGH) |=> !irq_o)
    else $error("pin active after flag read");
  od_style_a: assert property (@(posedge mclk) disable iff (any_reset)
    (!gcf_r[0] && !gcf_r[1] && $stable(gcf_r)) |=> (irq_o == 1'b0))
    else $error("open drain pin drove high");
  pp_low_a: assert property (@(posedge mclk) disable iff (any_reset)
    (style == PIN_PP_LOW && $stable(gcf_r)) |=> (irq_oe && irq_o == !$past(pending)))
    else $error("push-pull low wrong");
  soft_reset_a: assert property (@(posedge mclk) disable iff (rst)
    soft_trig |-> ##[1:2] chip_reset)
    else $error("soft reset did not reach chip");
  drivers_off_a: assert property (@(posedge mclk)
    any_reset |=> !line_drive_en)
    else $error("line drivers on after reset");

  // Push-pull high follows the pending state one cycle later
  pp_high_a: assert property (@(posedge mclk) disable iff (any_reset)
    (style == PIN_PP_HIGH && $stable(gcf_r)) |=> (irq_oe && irq_o == $past(pending)))
    else $error("push-pull high wrong");

  // Open drain only enables the driver while pending
  od_enable_a: assert property (@(posedge mclk) disable iff (any_reset)
    (!gcf_r[0] && !gcf_r[1] && $stable(gcf_r)) |=> (irq_oe == $past(pending)))
    else $error("open drain enable wrong");

  // Any unmasked high-byte flag shows on the pin
  any_pending_a: assert property (@(posedge mclk) disable iff (any_reset)
    (style == PIN_PP_HIGH && $stable(gcf_r) && (|(flag_hi_r & ~mask_hi_r)) && !req.rd)
    |=> irq_o)
    else $error("pending flag not on pin");

  // Flags hold until read
  flag_hold_a: assert property (@(posedge mclk) disable iff (any_reset)
    !(req.rd && req.addr == `OFS_FLAG_HIGH) |=> ((flag_hi_r & $past(flag_hi_r))
    == $past(flag_hi_r)))
    else $error("flag lost without read");

  // Event pulses latch into the high flag byte
  event_sets_a: assert property (@(posedge mclk) disable iff (any_reset)
    (event_high != 8'h00) |=> ((flag_hi_r & $past(event_high)) == $past(event_high)))
    else $error("event pulse not latched");

  // A new edge in the read cycle survives the clear
  set_wins_a: assert property (@(posedge mclk) disable iff (any_reset)
    (req.rd && req.addr == `OFS_FLAG_LOW && live_edge != 8'h00)
    |=> ((flag_lo_r & $past(live_edge)) == $past(live_edge)))
    else $error("read clear beat new event");

  // Edge select one sets the flag on a falling change too
  either_edge_a: assert property (@(posedge mclk) disable iff (any_reset)
    (live_low[2] != live_prev_r[2] && edge_r[2]) |=> flag_lo_r[2])
    else $error("either edge did not set flag");

  // Mask writes land at the next edge
  mask_write_a: assert property (@(posedge mclk) disable iff (any_reset)
    (req.wr && req.addr == `OFS_MASK_LOW) |=> (mask_lo_r == $past(req.wdata)))
    else $error("mask write lost");

  // Every reset loads defaults and flags the chip reset
  reset_defaults_a: assert property (@(posedge mclk)
    any_reset |=> (mask_lo_r == `RST_MASK && mask_hi_r == `RST_MASK
    && edge_r == `RST_EDGE_SEL && gcf_r == `RST_GLOBAL_CFG
    && flag_lo_r == `RST_FLAG && flag_hi_r == `RST_FLAG && chip_reset))
    else $error("reset left state behind");

  // Pin reset reaches the chip through the sampling flop
  hw_pin_a: assert property (@(posedge mclk)
    !hw_reset_n |-> ##2 chip_reset)
    else $error("reset pin ignored");

  // Soft reset lasts well past its trigger
  soft_len_a: assert property (@(posedge mclk) disable iff (rst)
    soft_trig |=> soft_busy [*8])
    else $error("soft reset too short");

  // A read answers one cycle later
  read_answer_a: assert property (@(posedge mclk) disable iff (any_reset)
    req.rd |=> rvalid)
    else $error("read not answered");
endmodule : line_irq_reset

// File: verification/host_irq_model.sv
module host_irq_model (
  input wire logic irq_o,
  input wire logic irq_oe,
  input wire irq_rst_pkg::pin_style_t style,
  output logic pin,
  output logic active
);
  timeunit 1ns;
  timeprecision 1ns;
  import irq_rst_pkg::*;
  // Board pull-up holds the line high when released
  assign pin = irq_oe ? irq_o : 1'b1;
  // Host decodes the active level from the style it set
  assign active = (style == PIN_PP_HIGH) ? pin : !pin;
endmodule : host_irq_model

// File: verification/line_irq_reset_bench.sv
`include "irq_rst_consts.svh"
module line_irq_reset_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_rst_pkg::*;
  logic mclk, rst, hw_reset_n, rvalid, irq_o, irq_oe, line_drive_en, chip_reset, pin, active;
  logic [7:0] rdata, live_low, live_high, event_high;
  reg_req_t req;
  pin_style_t style;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  line_irq_reset i_dut (
    .mclk(mclk), .rst(rst), .hw_reset_n(hw_reset_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .live_low(live_low), .live_high(live_high), .event_high(event_high),
    .irq_o(irq_o), .irq_oe(irq_oe), .line_drive_en(line_drive_en), .chip_reset(chip_reset)
  );
  host_irq_model i_host (
    .irq_o(irq_o), .irq_oe(irq_oe), .style(style), .pin(pin), .active(active)
  );

  // Clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    req.wr = 1'b0;
  endtask : wr

  // Read one register and compare it
  task automatic rc(input string what, input logic [4:0] a, input logic [7:0] exp);
    int n = 0;
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    req.rd = 1'b0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    chk(what, exp, rdata);
  endtask : rc

  task automatic pulse(input logic [7:0] e);
    @(negedge mclk);
    event_high = e;
    @(negedge mclk);
    event_high = 8'h00;
  endtask : pulse

  // Let flags and the pin settle, then judge the host's view
  task automatic pin_chk(input logic exp);
    repeat (3) @(negedge mclk);
    chk("irq active", {7'h00, exp}, {7'h00, active});
  endtask : pin_chk

  // Bounded wait for the chip reset flag
  task automatic wait_rst(input logic val);
    int n = 0;
    while (chip_reset !== val && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk("chip reset", {7'h00, val}, {7'h00, chip_reset});
  endtask : wait_rst

  // Main sequence
  initial begin
    rst = 1'b1;
    hw_reset_n = 1'b1;
    req = '0;
    live_low = 8'h00;
    live_high = 8'h00;
    event_high = 8'h00;
    style = PIN_OD_LOW;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk("drive en", 8'h00, {7'h00, line_drive_en});
    rc("mask low", `OFS_MASK_LOW, `RST_MASK);
    rc("mask high", `OFS_MASK_HIGH, `RST_MASK);
    rc("edge sel", `OFS_EDGE_SEL, `RST_EDGE_SEL);
    rc("unmapped", 5'h05, 8'h00);
    pulse(8'hff);
    pin_chk(1'b0);
    rc("flags high", `OFS_FLAG_HIGH, 8'hff);
    rc("flags high", `OFS_FLAG_HIGH, 8'h00);
    wr(`OFS_MASK_HIGH, 8'h00);
    for (int s = 0; s < 4; s++) begin
      style = pin_style_t'(s[1:0]);
      wr(`OFS_GLOBAL_CFG, {6'h00, s[1:0]});
      pulse(8'h02);
      pin_chk(1'b1);
      chk("pin level", {7'h00, s == 2}, {7'h00, pin});
      rc("flags high", `OFS_FLAG_HIGH, 8'h02);
      pin_chk(1'b0);
    end
    wr(`OFS_MASK_HIGH, 8'hfe);
    pulse(8'h02);
    pin_chk(1'b0);
    rc("flags high", `OFS_FLAG_HIGH, 8'h02);
    // Rising edge only, then either edge
    wr(`OFS_MASK_LOW, 8'h00);
    live_low = 8'hff;
    live_high = 8'h5a;
    pin_chk(1'b1);
    rc("live low", `OFS_LIVE_LOW, 8'hff);
    rc("live high", `OFS_LIVE_HIGH, 8'h5a);
    rc("flags low", `OFS_FLAG_LOW, 8'hff);
    live_low = 8'h00;
    rc("flags low", `OFS_FLAG_LOW, 8'h00);
    wr(`OFS_EDGE_SEL, 8'hff);
    live_low = 8'hff;
    rc("flags low", `OFS_FLAG_LOW, 8'hff);
    live_low = 8'h00;
    rc("flags low", `OFS_FLAG_LOW, 8'hff);
    // Soft reset by a write of any value
    wr(`OFS_GLOBAL_CFG, 8'h02);
    wr(`OFS_SOFT_RESET, 8'h5a);
    wait_rst(1'b1);
    chk("drive en", 8'h00, {7'h00, line_drive_en});
    wait_rst(1'b0);
    rc("gcf", `OFS_GLOBAL_CFG, `RST_GLOBAL_CFG);
    rc("edge sel", `OFS_EDGE_SEL, `RST_EDGE_SEL);
    // Hardware reset held 100 ns
    wr(`OFS_MASK_LOW, 8'h00);
    hw_reset_n = 1'b0;
    repeat (5) @(negedge mclk);
    hw_reset_n = 1'b1;
    wait_rst(1'b0);
    rc("mask low", `OFS_MASK_LOW, `RST_MASK);
    stop_test();
  end
endmodule : line_irq_reset_bench
